//--- pkg/mfs_pkg.sv
// Package for the memory fault status capture block.
// Assumes a classic Wishbone slave with 32-bit data and byte addresses.
`default_nettype none
package mfs_pkg;
   // Register byte offsets.
   localparam logic [3:0] OFF_STATUS   = 4'h0;
   localparam logic [3:0] OFF_ADDRESS  = 4'h4;
   localparam logic [3:0] OFF_IRQMASK  = 4'h8;
   localparam logic [3:0] OFF_FLAGSTAT = 4'hc;
   // Status field positions.
   localparam int BIT_IACC  = 0;
   localparam int BIT_DACC  = 1;
   localparam int BIT_UNSTK = 3;
   localparam int BIT_STK   = 4;
   localparam int BIT_VALID = 7;
   // Writable (write-one-to-clear) bits; 6:5 and 2 are reserved.
   localparam logic [7:0] STATUS_W1C_MASK = 8'h9b;
   localparam logic [7:0] STATUS_RESET    = 8'h00;
   localparam logic [7:0] MASK_RESET      = 8'h00;
   localparam logic [31:0] ADDR_RESET     = 32'h0000_0000;
   // Bus slave states, Gray coded.
   typedef enum logic [1:0]
   {
      MFS_IDLE = 2'b00,
      MFS_ACK  = 2'b01
   } mfs_bus_t;
endpackage
`default_nettype wire

//--- src/mfs_flag_cell.sv
// Holds one sticky fault flag: hardware sets, software clears by writing one.
// Assumes set and clear pulses synchronous to mclk.
`timescale 1ns/1ns
`default_nettype none
module mfs_flag_cell
(
   input  wire logic mclk,
   input  wire logic rst,
   input  wire logic setPulse,
   input  wire logic clearPulse,
   output logic      flag
);
   typedef struct packed
   {
      logic flag;
   } mfs_cell_t;

   mfs_cell_t state_q;
   mfs_cell_t state_d;

   // A set in the same cycle as a clear wins, so no event is lost.
   always_comb
   begin
      state_d = state_q;
      if (clearPulse)
      begin
         state_d.flag = 1'b0;
      end
      if (setPulse)
      begin
         state_d.flag = 1'b1;
      end
   end

   // Registers the flag.
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         state_q <= '0;
      end
      else
      begin
         state_q <= state_d;
      end
   end

   assign flag = state_q.flag;
endmodule
`default_nettype wire

//--- src/mem_fault_status_capture.sv
// Memory management fault status capture with its fault address register.
// Assumes the core fault logic gives one-cycle pulses and a Wishbone master.
`timescale 1ns/1ns
`default_nettype none
module mem_fault_status_capture
(
   input  wire logic        mclk,
   input  wire logic        rst,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [3:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic [31:0]      wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        stackEntryFault,
   input  wire logic        unstackReturnFault,
   input  wire logic        dataAccessFault,
   input  wire logic [31:0] dataFaultAddr,
   input  wire logic        fetchFault,
   input  wire logic        fetchExecuteNever,
   input  wire logic        mpuEnable,
   input  wire logic [31:0] faultPc,
   output logic             stackPointerAdjust,
   output logic             contextSave,
   output logic [31:0]      stackedPc,
   output logic             irq
);
   typedef struct packed
   {
      mfs_pkg::mfs_bus_t bus;
      logic [31:0]       rdata;
      logic [31:0]       faultAddr;
      logic [7:0]        mask;
      logic              spAdjust;
      logic              ctxSave;
      logic [31:0]       retPc;
   } mfs_state_t;

   mfs_state_t state_q;
   mfs_state_t state_d;
   logic [7:0] status;
   logic [7:0] setVec;
   logic [7:0] clrVec;
   logic       wrStatus;
   logic       busReq;

   // Checks one address against a register offset; byte lane selects are not looked at.
   function automatic logic hit(input logic [3:0] adr, input logic [3:0] off);
      hit = (adr == off);
   endfunction

   assign busReq   = wb_cyc_i && wb_stb_i && (state_q.bus == mfs_pkg::MFS_IDLE);
   assign wrStatus = busReq && wb_we_i && wb_sel_i[0] && hit(wb_adr_i, mfs_pkg::OFF_STATUS);

   // Event vector; execute-never fetches fault regardless of mpuEnable.
   always_comb
   begin
      setVec = 8'h00;
      setVec[mfs_pkg::BIT_STK]   = stackEntryFault;
      setVec[mfs_pkg::BIT_UNSTK] = unstackReturnFault;
      setVec[mfs_pkg::BIT_DACC]  = dataAccessFault;
      setVec[mfs_pkg::BIT_IACC]  = fetchFault || fetchExecuteNever;
      setVec[mfs_pkg::BIT_VALID] = dataAccessFault;
   end

   // Only ones written to writable bits clear; zeros and reserved bits do nothing.
   assign clrVec = wrStatus ? (wb_dat_i[7:0] & mfs_pkg::STATUS_W1C_MASK) : 8'h00;

   // One sticky cell per implemented flag; reserved cells stay zero.
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++)
      begin : g_flag
         if (mfs_pkg::STATUS_W1C_MASK[gi])
         begin : g_cell
            mfs_flag_cell u_cell
            (
               .mclk       (mclk),
               .rst        (rst),
               .setPulse   (setVec[gi]),
               .clearPulse (clrVec[gi]),
               .flag       (status[gi])
            );
         end
         else
         begin : g_res
            assign status[gi] = 1'b0;
         end
      end
   endgenerate

   // Next-state logic for bus slave, address capture and stacking controls.
   always_comb
   begin
      state_d = state_q;
      state_d.spAdjust = 1'b0;
      state_d.ctxSave  = 1'b0;
      if (dataAccessFault)
      begin
         state_d.faultAddr = dataFaultAddr;
      end
      // Stacking and unstacking faults never touch faultAddr.
      if (stackEntryFault)
      begin
         state_d.spAdjust = 1'b1;
         state_d.ctxSave  = 1'b1;
      end
      if (dataAccessFault || fetchFault || fetchExecuteNever)
      begin
         state_d.retPc    = faultPc;
         state_d.spAdjust = 1'b1;
         state_d.ctxSave  = 1'b1;
      end
      if (unstackReturnFault)
      begin
         state_d.spAdjust = 1'b0;
         state_d.ctxSave  = 1'b0;
      end
      case (state_q.bus)
         mfs_pkg::MFS_IDLE:
         begin
            if (busReq)
            begin
               state_d.bus   = mfs_pkg::MFS_ACK;
               state_d.rdata = 32'h0000_0000;
               if (hit(wb_adr_i, mfs_pkg::OFF_STATUS))
               begin
                  state_d.rdata = {24'h00_0000, status};
               end
               else if (hit(wb_adr_i, mfs_pkg::OFF_ADDRESS))
               begin
                  state_d.rdata = state_q.faultAddr;
                  // A data fault in the same cycle keeps its captured address, so software cannot mask it.
                  if (wb_we_i && !dataAccessFault)
                  begin
                     if (wb_sel_i[0])
                     begin
                        state_d.faultAddr[7:0] = wb_dat_i[7:0];
                     end
                     if (wb_sel_i[1])
                     begin
                        state_d.faultAddr[15:8] = wb_dat_i[15:8];
                     end
                     if (wb_sel_i[2])
                     begin
                        state_d.faultAddr[23:16] = wb_dat_i[23:16];
                     end
                     if (wb_sel_i[3])
                     begin
                        state_d.faultAddr[31:24] = wb_dat_i[31:24];
                     end
                  end
               end
               else if (hit(wb_adr_i, mfs_pkg::OFF_IRQMASK))
               begin
                  state_d.rdata = {24'h00_0000, state_q.mask};
                  if (wb_we_i && wb_sel_i[0])
                  begin
                     state_d.mask = wb_dat_i[7:0] & mfs_pkg::STATUS_W1C_MASK;
                  end
               end
               else if (hit(wb_adr_i, mfs_pkg::OFF_FLAGSTAT))
               begin
                  state_d.rdata = {31'h0000_0000, mpuEnable};
               end
            end
         end
         mfs_pkg::MFS_ACK:
         begin
            state_d.bus = mfs_pkg::MFS_IDLE;
         end
         default:
         begin
            state_d.bus = mfs_pkg::MFS_IDLE;
         end
      endcase
   end

   // Registers all state.
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         state_q.bus       <= mfs_pkg::MFS_IDLE;
         state_q.rdata     <= 32'h0000_0000;
         state_q.faultAddr <= mfs_pkg::ADDR_RESET;
         state_q.mask      <= mfs_pkg::MASK_RESET;
         state_q.spAdjust  <= 1'b0;
         state_q.ctxSave   <= 1'b0;
         state_q.retPc     <= 32'h0000_0000;
      end
      else
      begin
         state_q <= state_d;
      end
   end

   assign wb_ack_o           = (state_q.bus == mfs_pkg::MFS_ACK);
   assign wb_dat_o           = state_q.rdata;
   assign stackPointerAdjust = state_q.spAdjust;
   assign contextSave        = state_q.ctxSave;
   assign stackedPc          = state_q.retPc;
   // Level interrupt while an unmasked status bit is set.
   assign irq = |(status & state_q.mask);

   // Each fault event sets its own sticky flag one cycle later.
   a_stk_sets: assert property (@(posedge mclk) disable iff (rst)
      stackEntryFault
      |=> status[mfs_pkg::BIT_STK])
      else $error("stack flag not set");
   a_unstk_sets: assert property (@(posedge mclk) disable iff (rst)
      unstackReturnFault
      |=> status[mfs_pkg::BIT_UNSTK])
      else $error("unstack flag not set");
   a_data_sets: assert property (@(posedge mclk) disable iff (rst)
      dataAccessFault
      |=> status[mfs_pkg::BIT_DACC])
      else $error("data flag not set");
   a_fetch_sets: assert property (@(posedge mclk) disable iff (rst)
      fetchFault
      |=> status[mfs_pkg::BIT_IACC])
      else $error("fetch flag not set");
   a_xn_fetch: assert property (@(posedge mclk) disable iff (rst)
      (fetchExecuteNever && !mpuEnable)
      |=> status[mfs_pkg::BIT_IACC])
      else $error("xn fetch missed");

   // Only a data fault captures an address and marks it valid; other faults leave it alone.
   a_data_capture: assert property (@(posedge mclk) disable iff (rst)
      dataAccessFault
      |=> (status[mfs_pkg::BIT_VALID] && state_q.faultAddr == $past(dataFaultAddr)))
      else $error("data fault not captured");
   a_valid_source: assert property (@(posedge mclk) disable iff (rst)
      (!dataAccessFault && !status[mfs_pkg::BIT_VALID])
      |=> !status[mfs_pkg::BIT_VALID])
      else $error("valid flag set without data fault");
   a_addr_held: assert property (@(posedge mclk) disable iff (rst)
      (status[mfs_pkg::BIT_VALID] && !dataAccessFault && !busReq)
      |=> $stable(state_q.faultAddr))
      else $error("valid address changed");
   a_stk_noaddr: assert property (@(posedge mclk) disable iff (rst)
      (stackEntryFault && !dataAccessFault && !busReq)
      |=> $stable(state_q.faultAddr))
      else $error("stack fault wrote address");
   a_unstk_noaddr: assert property (@(posedge mclk) disable iff (rst)
      (unstackReturnFault && !dataAccessFault && !busReq)
      |=> $stable(state_q.faultAddr))
      else $error("unstack fault wrote address");
   a_fetch_noaddr: assert property (@(posedge mclk) disable iff (rst)
      ((fetchFault || fetchExecuteNever) && !dataAccessFault && !busReq)
      |=> $stable(state_q.faultAddr))
      else $error("fetch fault wrote address");

   // Stacking controls and the stacked return pc.
   a_stk_adjust: assert property (@(posedge mclk) disable iff (rst)
      (stackEntryFault && !unstackReturnFault)
      |=> stackPointerAdjust)
      else $error("stack fault did not adjust sp");
   a_unstk_nosave: assert property (@(posedge mclk) disable iff (rst)
      unstackReturnFault
      |=> (!stackPointerAdjust && !contextSave))
      else $error("unstack adjusted sp");
   a_data_pc: assert property (@(posedge mclk) disable iff (rst)
      dataAccessFault
      |=> (stackedPc == $past(faultPc)))
      else $error("data fault pc not stacked");
   a_fetch_pc: assert property (@(posedge mclk) disable iff (rst)
      (fetchFault || fetchExecuteNever)
      |=> (stackedPc == $past(faultPc)))
      else $error("fetch fault pc not stacked");

   // Reserved positions of status and mask never hold a one.
   a_reserved_zero: assert property (@(posedge mclk) disable iff (rst)
      ((status & ~mfs_pkg::STATUS_W1C_MASK) == 8'h00)
      && ((state_q.mask & ~mfs_pkg::STATUS_W1C_MASK) == 8'h00))
      else $error("reserved bit set");

   // Software clears: a one clears its own flag only, zeros do nothing, events win.
   a_set_wins: assert property (@(posedge mclk) disable iff (rst)
      (wrStatus && wb_dat_i[mfs_pkg::BIT_IACC] && (fetchFault || fetchExecuteNever))
      |=> status[mfs_pkg::BIT_IACC])
      else $error("set lost to clear");
   a_zero_write: assert property (@(posedge mclk) disable iff (rst)
      (wrStatus && !wb_dat_i[mfs_pkg::BIT_VALID] && status[mfs_pkg::BIT_VALID])
      |=> status[mfs_pkg::BIT_VALID])
      else $error("zero write cleared flag");
   a_clear_one: assert property (@(posedge mclk) disable iff (rst)
      (wrStatus && wb_dat_i[mfs_pkg::BIT_UNSTK] && !wb_dat_i[mfs_pkg::BIT_STK]
       && !unstackReturnFault && !stackEntryFault && status[mfs_pkg::BIT_STK])
      |=> (!status[mfs_pkg::BIT_UNSTK] && status[mfs_pkg::BIT_STK]))
      else $error("w1c disturbed others");
   a_clear_valid: assert property (@(posedge mclk) disable iff (rst)
      (wrStatus && wb_dat_i[mfs_pkg::BIT_VALID] && !dataAccessFault)
      |=> !status[mfs_pkg::BIT_VALID])
      else $error("valid flag not cleared");
endmodule
`default_nettype wire

//--- verif/mfs_core_model.sv
// Behavioural model of the core fault detection and stacking logic.
// Assumes the bench raises go for one cycle, changed just after a clock edge.
`timescale 1ns/1ns
`default_nettype none
module mfs_core_model
(
   input  wire logic        go,
   input  wire logic [2:0]  kind,
   input  wire logic [31:0] addrIn,
   input  wire logic [31:0] pcIn,
   output logic             stackEntryFault,
   output logic             unstackReturnFault,
   output logic             dataAccessFault,
   output logic [31:0]      dataFaultAddr,
   output logic             fetchFault,
   output logic             fetchExecuteNever,
   output logic [31:0]      faultPc
);
   // Decodes the event kind into one pulse; address and pc are driven inverted when idle.
   always_comb
   begin
      stackEntryFault    = go && kind == 3'h0;
      unstackReturnFault = go && kind == 3'h1;
      dataAccessFault    = go && kind == 3'h2;
      fetchFault         = go && kind == 3'h3;
      fetchExecuteNever  = go && kind == 3'h4;
      dataFaultAddr      = go ? addrIn : ~addrIn;
      faultPc            = go ? pcIn : ~pcIn;
   end
endmodule
`default_nettype wire

//--- verif/mem_fault_status_capture_test.sv
// Bench for the fault status block: Wishbone tasks plus fault events.
// Assumes the core model in the same folder and the block's package.
`timescale 1ns/1ns
`default_nettype none
module mem_fault_status_capture_test;
   logic mclk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, go = 1'b0, memory_protection_unit = 1'b0;
   logic [3:0] adr = 4'h0, sel = 4'hf;
   logic [2:0] kind = 3'h0;
   logic [31:0] dat = 32'h0, fa = 32'h0, fp = 32'h0, q;
   logic [31:0] rdat, spc;
   logic ack, sef, urf, daf, ffl, fxn, spa, csv, irq;
   logic [31:0] dfa, fpc;
   int fails = 0, n_compared = 0, spCnt = 0, svCnt = 0, c0, c1;
   mfs_core_model i_mfs_core_model (.go(go), .kind(kind), .addrIn(fa), .pcIn(fp), .stackEntryFault(sef),
      .unstackReturnFault(urf), .dataAccessFault(daf), .dataFaultAddr(dfa), .fetchFault(ffl),
      .fetchExecuteNever(fxn), .faultPc(fpc));
   mem_fault_status_capture i_mem_fault_status_capture (.mclk(mclk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .stackEntryFault(sef), .unstackReturnFault(urf), .dataAccessFault(daf), .dataFaultAddr(dfa),
      .fetchFault(ffl), .fetchExecuteNever(fxn), .mpuEnable(memory_protection_unit), .faultPc(fpc),
      .stackPointerAdjust(spa), .contextSave(csv), .stackedPc(spc), .irq(irq));
   // Clock at 25 MHz.
   initial
   begin
      forever #20 mclk = ~mclk;
   end
   // Counts the stack adjust and context save pulses.
   always @(posedge mclk)
   begin
      spCnt += (spa === 1'b1);
      svCnt += (csv === 1'b1);
   end
   // Compares one value and reports a mismatch.
   task automatic chk(input string s, input logic [31:0] e, input logic [31:0] v);
      n_compared++;
      if (v !== e)
      begin
         fails++;
         $display("wrong value %s expected %h seen %h", s, e, v);
      end
   endtask
   // One classic cycle; f raises a fault event at the taking edge.
   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d, input logic f);
      int n;
      n = 0;
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d; go <= f;
      @(posedge mclk);
      go <= 1'b0;
      while (ack !== 1'b1 && n < 20)
      begin
         @(posedge mclk);
         n++;
      end
      if (n >= 20) fails++;
      q = rdat;
      cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
      @(posedge mclk);
   endtask
   // Reads a register and compares it.
   task automatic rd(input logic [3:0] a, input logic [31:0] e, input string s);
      wb(1'b0, a, 32'h0, 1'b0);
      chk(s, e, q);
   endtask
   // Raises one fault event from the core model.
   task automatic fault(input logic [2:0] k, input logic [31:0] a, input logic [31:0] p);
      kind <= k; fa <= a; fp <= p; go <= 1'b1;
      @(posedge mclk);
      go <= 1'b0;
      @(posedge mclk);
   endtask
   // Prints the counts and the verdict, then ends the run.
   task automatic test_done();
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // Ends a hung run.
   initial
   begin
      #100000;
      fails++;
      test_done();
   end
   // Test sequence.
   initial
   begin
      repeat (8) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      rd(4'h0, 32'h0, "status");
      rd(4'h8, 32'h0, "mask");
      rd(4'h2, 32'h0, "unmapped");
      $display("test reset done");
      fault(3'h2, 32'h2000_0040, 32'h0000_0100);
      rd(4'h0, 32'h82, "status");
      rd(4'h4, 32'h2000_0040, "address");
      chk("stackedPc", 32'h0000_0100, spc);
      c0 = spCnt;
      fault(3'h0, 32'h3000_0000, 32'h0000_0200);
      rd(4'h0, 32'h92, "status");
      chk("adjust", 32'h1, 32'(spCnt - c0));
      rd(4'h4, 32'h2000_0040, "address");
      c0 = spCnt;
      c1 = svCnt;
      fault(3'h1, 32'h3000_0004, 32'h0000_0300);
      rd(4'h0, 32'h9a, "status");
      chk("adjust", 32'h0, 32'(spCnt - c0 + svCnt - c1));
      rd(4'h4, 32'h2000_0040, "address");
      fault(3'h4, 32'h3000_0008, 32'h0000_0400);
      rd(4'h0, 32'h9b, "status");
      chk("stackedPc", 32'h0000_0400, spc);
      rd(4'h4, 32'h2000_0040, "address");
      $display("test events done");
      wb(1'b1, 4'h0, 32'h0, 1'b0);
      rd(4'h0, 32'h9b, "status");
      wb(1'b1, 4'h0, 32'h64, 1'b0);
      rd(4'h0, 32'h9b, "status");
      wb(1'b1, 4'h0, 32'h08, 1'b0);
      rd(4'h0, 32'h93, "status");
      wb(1'b1, 4'h0, 32'h01, 1'b0);
      rd(4'h0, 32'h92, "status");
      wb(1'b1, 4'h0, 32'h80, 1'b0);
      rd(4'h0, 32'h12, "status");
      wb(1'b1, 4'h0, 32'h1a, 1'b0);
      memory_protection_unit <= 1'b1;
      rd(4'hc, 32'h1, "mpuEnable");
      fault(3'h3, 32'h0, 32'h0000_0500);
      rd(4'h0, 32'h01, "status");
      kind <= 3'h3;
      wb(1'b1, 4'h0, 32'h01, 1'b1);
      rd(4'h0, 32'h01, "status");
      $display("test clear done");
      chk("irq", 32'h0, {31'h0, irq});
      wb(1'b1, 4'h8, 32'h01, 1'b0);
      rd(4'h8, 32'h01, "mask");
      chk("irq", 32'h1, {31'h0, irq});
      wb(1'b1, 4'h0, 32'h01, 1'b0);
      fault(3'h2, 32'h2000_0080, 32'h0000_0600);
      chk("irq", 32'h0, {31'h0, irq});
      wb(1'b1, 4'h8, 32'h02, 1'b0);
      chk("irq", 32'h1, {31'h0, irq});
      rd(4'h0, 32'h82, "status");
      $display("test irq done");
      rd(4'h4, 32'h2000_0080, "address");
      wb(1'b1, 4'h4, 32'h1234_5678, 1'b0);
      rd(4'h4, 32'h1234_5678, "address");
      kind <= 3'h2;
      fa <= 32'h2000_00c0;
      wb(1'b1, 4'h4, 32'h5555_aaaa, 1'b1);
      rd(4'h4, 32'h2000_00c0, "address");
      $display("test address done");
      test_done();
   end
endmodule
`default_nettype wire
